// ===== hw/dac_pkg.sv
// Purpose: shared constants of the dual converter control block
// Assumes: 32-bit AXI4-Lite register bus, one clock
// Notes:   byte offsets, field positions, sample formats and trigger codes
package dac_pkg;
	localparam int AW      = 6;
	localparam int DW      = 12;
	localparam int W8      = 8;
	localparam int L12_LSB = 4;
	localparam int LANE16  = 16;
	localparam int LANE8   = 8;
	// register byte offsets
	localparam logic [AW-1:0] OFS_CTRL  = 6'h00;
	localparam logic [AW-1:0] OFS_SWT   = 6'h04;
	localparam logic [AW-1:0] OFS_H12R1 = 6'h08;
	localparam logic [AW-1:0] OFS_H12L1 = 6'h0c;
	localparam logic [AW-1:0] OFS_H8R1  = 6'h10;
	localparam logic [AW-1:0] OFS_H12R2 = 6'h14;
	localparam logic [AW-1:0] OFS_H12L2 = 6'h18;
	localparam logic [AW-1:0] OFS_H8R2  = 6'h1c;
	localparam logic [AW-1:0] OFS_D12R  = 6'h20;
	localparam logic [AW-1:0] OFS_D12L  = 6'h24;
	localparam logic [AW-1:0] OFS_D8R   = 6'h28;
	localparam logic [AW-1:0] OFS_OUT1  = 6'h2c;
	localparam logic [AW-1:0] OFS_OUT2  = 6'h30;
	localparam logic [AW-1:0] OFS_STS   = 6'h34;
	// word indices used by the decoder
	localparam logic [3:0] IDX_CTRL  = OFS_CTRL[AW-1:2];
	localparam logic [3:0] IDX_SWT   = OFS_SWT[AW-1:2];
	localparam logic [3:0] IDX_H12R1 = OFS_H12R1[AW-1:2];
	localparam logic [3:0] IDX_H8R1  = OFS_H8R1[AW-1:2];
	localparam logic [3:0] IDX_H12R2 = OFS_H12R2[AW-1:2];
	localparam logic [3:0] IDX_D12R  = OFS_D12R[AW-1:2];
	localparam logic [3:0] IDX_OUT1  = OFS_OUT1[AW-1:2];
	localparam logic [3:0] IDX_OUT2  = OFS_OUT2[AW-1:2];
	localparam logic [3:0] IDX_STS   = OFS_STS[AW-1:2];
	// control fields, channel two sits CH2_OFS higher
	localparam int CH2_OFS = 16;
	localparam int F_ON    = 0;
	localparam int F_BUF   = 1;
	localparam int F_TRG   = 2;
	localparam int F_SEL   = 3;
	localparam int F_WAVE  = 6;
	localparam int F_AMP   = 8;
	localparam int F_DMA   = 12;
	localparam int F_UIE   = 13;
	localparam int F_UDR   = 13;
	localparam logic [31:0] CTRL_MASK = 32'h3fff3fff;
	localparam logic [31:0] RST_ZERO  = 32'h00000000;
	// holding formats, in register order inside each group
	localparam logic [1:0] FMT_L12 = 2'h1;
	localparam logic [1:0] FMT_R8  = 2'h2;
	localparam int         N_FMT   = 3;
	localparam logic [1:0] ONE_CH1 = 2'h1;
	localparam logic [1:0] ONE_CH2 = 2'h2;
	localparam logic [1:0] BOTH_CH = 2'h3;
	// trigger and waveform
	localparam logic [2:0]  SRC_SW      = 3'h7;
	localparam int          TMR_DELAY   = 3;
	localparam logic [1:0]  WAVE_NOISE  = 2'h1;
	localparam logic [3:0]  AMP_MAX_SEL = 4'hb;
	localparam logic [11:0] AMP_FULL    = 12'hfff;
	localparam logic [11:0] LFSR_SEED   = 12'haaa;
	localparam logic [11:0] LFSR_TAPS   = 12'h829;
	typedef enum logic [1:0] {TRI_UP = 2'b01, TRI_DOWN = 2'b10} tri_dir_e;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dac_pkg

// ===== hw/dac_trig.sv
// Purpose: picks the move moment of one channel
// Assumes: timer and line events are one cycle wide, synchronous to aclk
// Notes:   hardware events pass two stages so the move lands three cycles later
`timescale 1ns/1ps

module dac_trig (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// configuration
	input  wire logic       trig_on,
	input  wire logic [2:0] source,
	// events
	input  wire logic [5:0] timer_evt,
	input  wire logic       ext_evt,
	input  wire logic       soft_kick,
	input  wire logic       held_write,
	// move request
	output logic            fire
);
	logic [7:0]                    src_vec;
	logic                          hw_evt;
	logic [dac_pkg::TMR_DELAY-2:0] stage;
	logic                          pend;

	// code 7 is the software kick, handled apart
	assign src_vec = {1'b0, ext_evt, timer_evt};
	assign hw_evt  = src_vec[source] & trig_on;
	assign fire    = trig_on ? (stage[dac_pkg::TMR_DELAY-2]
		| (soft_kick & (source == dac_pkg::SRC_SW))) : pend;

	// delay line; pend gives the one cycle lag of untriggered writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage <= '0;
			pend  <= 1'b0;
		end else begin
			stage <= {stage[dac_pkg::TMR_DELAY-3:0], hw_evt};
			pend  <= held_write & ~trig_on;
		end
	end
endmodule : dac_trig

// ===== hw/dac_wave.sv
// Purpose: noise and triangle generator of one channel
// Assumes: step pulses once per move
// Notes:   the value is added to the held sample by the caller
`timescale 1ns/1ps

module dac_wave (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// control
	input  wire logic        step,
	input  wire logic [1:0]  kind,
	input  wire logic [3:0]  sel,
	// offset to add
	output logic      [11:0] wave
);
	logic [11:0]        lfsr;
	logic [11:0]        tri_cnt;
	logic [11:0]        amp;
	dac_pkg::tri_dir_e  dir;

	// selector n gives mask and peak 2^(n+1)-1, saturating at full scale
	assign amp  = (sel >= dac_pkg::AMP_MAX_SEL) ? dac_pkg::AMP_FULL
		: 12'((13'h2 << sel) - 13'h1);
	assign wave = kind[1] ? tri_cnt
		: (kind == dac_pkg::WAVE_NOISE) ? (lfsr & amp) : 12'h0;

	// generators hold still unless their mode is chosen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lfsr    <= dac_pkg::LFSR_SEED;
			tri_cnt <= '0;
			dir     <= dac_pkg::TRI_UP;
		end else if (step && kind == dac_pkg::WAVE_NOISE) begin
			lfsr <= {lfsr[10:0], ^(lfsr & dac_pkg::LFSR_TAPS)};
		end else if (step && kind[1]) begin
			unique case (dir)
				dac_pkg::TRI_UP: begin
					if (tri_cnt < amp) tri_cnt <= tri_cnt + 12'h1;
					else begin
						tri_cnt <= tri_cnt - 12'h1;
						dir     <= dac_pkg::TRI_DOWN;
					end
				end
				dac_pkg::TRI_DOWN: begin
					if (tri_cnt != 12'h0) tri_cnt <= tri_cnt - 12'h1;
					else begin
						tri_cnt <= tri_cnt + 12'h1;
						dir     <= dac_pkg::TRI_UP;
					end
				end
			endcase
		end
	end
endmodule : dac_wave

// ===== hw/dac_ctrl.sv
// Purpose: register bank, triggers, DMA requests and codes of a two channel converter
// Assumes: AXI4-Lite, one write and one read in flight, events one cycle wide
// Notes:   the analog side sees codes, enables and buffer controls only
`timescale 1ns/1ps

// Operation
// R1: enable bit per channel, bits 0 and 16
// R2: buffer-off bit, 0 keeps buffer on
// R3: trigger enable gates the selected trigger
// R4: channel one source, 110 line, 111 software
// R5: codes 000-101 pick timers 6,8,7,5,2,4
// R6: channel two source field at 21:19
// R7: wave field: none, noise, triangle
// R8: selector sets noise mask or triangle peak
// R9: DMA enable makes request per move; the code requests only on moves with trigger enable set
// R10: underrun flag with enable raises interrupt
// R11: software kick bit, cleared after move
// R12: channel one right 12-bit holding at 0x08
// R13: channel one left 12-bit holding at 0x0c
// R14: channel one 8-bit holding at 0x10
// R15: channel two holding registers, same layouts
// R16: dual right 12-bit loads both channels
// R17: dual left 12-bit loads both channels
// R18: dual 8-bit loads both channels
// R19: read-only output code registers
// R20: channel one underrun flag, write 1 clears
// R21: channel two underrun flag at bit 29
// R22: all registers reset to zero
// R23: untriggered write moves after one cycle
// R24: hardware trigger three cycles, software one
// R25: 8-bit to top, left shifted down
module dac_ctrl (
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// write address and data channels
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [dac_pkg::AW-1:0]  awaddr,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	// write response channel
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic      [1:0]              bresp,
	// read channels
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [dac_pkg::AW-1:0]  araddr,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic      [31:0]             rdata,
	output logic      [1:0]              rresp,
	// trigger events
	input  wire logic                    timer_six_trigger_out,
	input  wire logic                    timer_eight_trigger_out,
	input  wire logic                    timer_seven_trigger_out,
	input  wire logic                    timer_five_trigger_out,
	input  wire logic                    timer_two_trigger_out,
	input  wire logic                    timer_four_trigger_out,
	input  wire logic                    ext_line_nine,
	// DMA handshake, index 0 is channel one
	input  wire logic [1:0]              dma_ack,
	output logic      [1:0]              dma_req,
	output logic      [1:0]              underrun_irq,
	// analog side
	output logic      [1:0]              chan_on,
	output logic      [1:0]              chan_buffer_off,
	output logic      [11:0]             code_one,
	output logic      [11:0]             code_two
);
	localparam int NCH = 2;

	logic [dac_pkg::AW-1:0] wr_addr;
	logic [31:0]            wr_data;
	logic [3:0]             wr_strb;
	logic                   do_write;
	logic [3:0]             widx;
	logic [3:0]             ridx;
	logic                   wr_map;
	logic                   rd_map;
	logic [31:0]            wmask;
	logic [31:0]            merged;
	logic [1:0]             wr_chans;
	logic [1:0]             wr_fmt;
	logic                   kick_wr;
	logic                   sts_wr;
	logic [5:0]             timer_evt;
	logic [31:0]            ctrl;
	logic [NCH-1:0]         kick;
	logic [NCH-1:0]         flag;
	logic [11:0]            hold [NCH];
	logic [11:0]            out  [NCH];

	// which channels a holding word feeds
	function automatic logic [1:0] hold_chans(input logic [3:0] idx);
		if (idx >= dac_pkg::IDX_H12R1 && idx < dac_pkg::IDX_H12R2)
			hold_chans = dac_pkg::ONE_CH1;
		else if (idx >= dac_pkg::IDX_H12R2 && idx < dac_pkg::IDX_D12R)
			hold_chans = dac_pkg::ONE_CH2;
		else if (idx >= dac_pkg::IDX_D12R && idx < dac_pkg::IDX_OUT1)
			hold_chans = dac_pkg::BOTH_CH;
		else
			hold_chans = 2'h0;
	endfunction : hold_chans

	// each group runs right 12, left 12, right 8
	function automatic logic [1:0] hold_fmt(input logic [3:0] idx);
		hold_fmt = 2'((idx - dac_pkg::IDX_H12R1) % dac_pkg::N_FMT);
	endfunction : hold_fmt

	// lane 1 is the upper channel of a dual word
	function automatic int lane_shift(input logic [1:0] fmt, input logic lane);
		lane_shift = lane ? ((fmt == dac_pkg::FMT_R8) ? dac_pkg::LANE8 : dac_pkg::LANE16) : 0;
	endfunction : lane_shift

	// bus word to right-aligned 12-bit sample
	function automatic logic [11:0] unpack(input logic [1:0] fmt, input logic [31:0] w,
		input logic lane);
		logic [31:0] s;
		s = w >> lane_shift(fmt, lane);
		if (fmt == dac_pkg::FMT_L12) unpack = s[dac_pkg::L12_LSB +: dac_pkg::DW];
		else if (fmt == dac_pkg::FMT_R8) unpack = {s[dac_pkg::W8-1:0], 4'h0};
		else unpack = s[dac_pkg::DW-1:0];
	endfunction : unpack

	// sample back to its place in the bus word
	function automatic logic [31:0] pack(input logic [1:0] fmt, input logic [11:0] v,
		input logic lane);
		logic [31:0] s;
		if (fmt == dac_pkg::FMT_L12) s = {20'h0, v} << dac_pkg::L12_LSB;
		else if (fmt == dac_pkg::FMT_R8) s = {24'h0, v[11:4]};
		else s = {20'h0, v};
		pack = s << lane_shift(fmt, lane);
	endfunction : pack

	// register read view; the kick register is write only and reads zero
	function automatic logic [31:0] reg_read(input logic [3:0] idx);
		logic [1:0] c;
		c = hold_chans(idx);
		reg_read = 32'h0;
		if (idx == dac_pkg::IDX_CTRL) reg_read = ctrl;
		else if (idx == dac_pkg::IDX_OUT1) reg_read = {20'h0, out[0]}; // [R19]
		else if (idx == dac_pkg::IDX_OUT2) reg_read = {20'h0, out[1]}; // [R19]
		else if (idx == dac_pkg::IDX_STS)
			reg_read = (32'(flag[0]) << dac_pkg::F_UDR)
				| (32'(flag[1]) << (dac_pkg::F_UDR + dac_pkg::CH2_OFS));
		else if (c != 2'h0)
			reg_read = (c[0] ? pack(hold_fmt(idx), hold[0], 1'b0) : 32'h0)
				| (c[1] ? pack(hold_fmt(idx), hold[1], c[0]) : 32'h0);
	endfunction : reg_read

	// address decode; both addresses and data must be held before a write acts
	assign widx     = wr_addr[dac_pkg::AW-1:2];
	assign ridx     = araddr[dac_pkg::AW-1:2];
	assign wr_map   = widx <= dac_pkg::IDX_STS;
	assign rd_map   = ridx <= dac_pkg::IDX_STS;
	assign do_write = ~awready & ~wready & ~bvalid;
	assign wr_chans = hold_chans(widx);
	assign wr_fmt   = hold_fmt(widx);
	assign kick_wr  = do_write && widx == dac_pkg::IDX_SWT;
	assign sts_wr   = do_write && widx == dac_pkg::IDX_STS;
	assign merged   = (reg_read(widx) & ~wmask) | (wr_data & wmask);

	// byte enables widen to a bit mask
	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign wmask[b*8 +: 8] = {8{wr_strb[b]}};
	end

	// code 000 is timer six, upward as listed
	assign timer_evt = {timer_four_trigger_out, timer_two_trigger_out, // [R5]
		timer_five_trigger_out, timer_seven_trigger_out,
		timer_eight_trigger_out, timer_six_trigger_out};

	// outputs wired from their flops
	assign code_one = out[0];
	assign code_two = out[1];

	// write channels; address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= dac_pkg::RESP_OKAY;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready  <= 1'b0;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= wr_map ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read channel; data are sampled at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= dac_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_map ? reg_read(ridx) : 32'h0;
			rresp   <= rd_map ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// control word; reserved bits stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) ctrl <= dac_pkg::RST_ZERO; // [R22]
		else if (do_write && widx == dac_pkg::IDX_CTRL) ctrl <= merged & dac_pkg::CTRL_MASK; // [R1]
	end

	// one slice per channel, channel two fields sit CH2_OFS higher
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam int B = c * dac_pkg::CH2_OFS;
		logic        on;
		logic        trg;
		logic        dma_on;
		logic        uie;
		logic [2:0]  src;
		logic [1:0]  kind;
		logic [3:0]  sel;
		logic [11:0] wave;
		logic        hold_wr;
		logic        fire;
		logic        move;
		logic        underrun;
		logic        clr_flag;
		logic        next_flag;
		logic        next_kick;
		logic [11:0] hold_q;
		logic [11:0] out_q;
		logic        kick_q;
		logic        flag_q;
		logic        req_q;
		logic        irq_q;

		// field taps of this channel
		assign on     = ctrl[B + dac_pkg::F_ON]; // [R1]
		assign trg    = ctrl[B + dac_pkg::F_TRG]; // [R3]
		assign src    = ctrl[B + dac_pkg::F_SEL +: 3]; // [R4] [R6]
		assign kind   = ctrl[B + dac_pkg::F_WAVE +: 2]; // [R7]
		assign sel    = ctrl[B + dac_pkg::F_AMP +: 4]; // [R8]
		assign dma_on = ctrl[B + dac_pkg::F_DMA]; // [R9]
		assign uie    = ctrl[B + dac_pkg::F_UIE]; // [R10]
		assign chan_on[c]         = on;
		assign chan_buffer_off[c] = ctrl[B + dac_pkg::F_BUF]; // [R2]

		// holding writes; lane 1 only for the dual words
		assign hold_wr = do_write && wr_chans[c]; // [R12] [R13] [R14] [R15]
		assign move    = fire & on;
		// a move with a request still open means the DMA fell behind
		assign underrun  = move & trg & dma_on & req_q & ~dma_ack[c];
		assign clr_flag  = sts_wr & wmask[dac_pkg::F_UDR + B] & wr_data[dac_pkg::F_UDR + B];
		assign next_flag = underrun | (flag_q & ~clr_flag); // [R20] [R21]
		// a fresh kick write wins over the hardware clear
		assign next_kick = (kick_wr && wr_strb[0]) ? wr_data[c]
			: kick_q & ~(move & trg & src == dac_pkg::SRC_SW); // [R11]

		dac_trig u_trig (
			.aclk       (aclk),
			.aresetn    (aresetn),
			.trig_on    (trg),
			.source     (src),
			.timer_evt  (timer_evt),
			.ext_evt    (ext_line_nine),
			.soft_kick  (kick_q),
			.held_write (hold_wr),
			.fire       (fire)
		); // [R23] [R24]

		dac_wave u_wave (
			.aclk    (aclk),
			.aresetn (aresetn),
			.step    (move),
			.kind    (kind),
			.sel     (sel),
			.wave    (wave)
		); // [R7] [R8]

		// channel state; the code wraps if sample plus wave passes full scale
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				hold_q <= '0; // [R22]
				out_q  <= '0;
				kick_q <= 1'b0;
				flag_q <= 1'b0;
				req_q  <= 1'b0;
				irq_q  <= 1'b0;
			end else begin
				if (hold_wr) hold_q <= unpack(wr_fmt, merged,
					1'(c == 1 && wr_chans == dac_pkg::BOTH_CH)); // [R16] [R17] [R18] [R25]
				if (move) out_q <= 12'(hold_q + wave); // [R19]
				kick_q <= next_kick;
				flag_q <= next_flag;
				req_q  <= (move & trg & dma_on) | (req_q & dma_on & ~dma_ack[c]); // [R9]
				irq_q  <= next_flag & uie; // [R10]
			end
		end

		assign hold[c]         = hold_q;
		assign out[c]          = out_q;
		assign kick[c]         = kick_q;
		assign flag[c]         = flag_q;
		assign dma_req[c]      = req_q;
		assign underrun_irq[c] = irq_q;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_notrig_move: // [R23]
	assert property (do_write && widx == dac_pkg::IDX_H12R1 && &wr_strb && !ctrl[2]
		&& ctrl[0] && ctrl[7:6] == 2'h0 |=> ##1 code_one == $past(hold[0]))
	else $error("untriggered write not moved after one cycle");

	a_timer_delay: // [R24]
	assert property (ctrl[0] && ctrl[2] && ctrl[5:3] == 3'h0 && timer_six_trigger_out
		|-> ##2 (g_ch[0].fire || !ctrl[2]))
	else $error("timer trigger move not three cycles later");

	a_kick_clear: // [R11]
	assert property (g_ch[0].move && kick[0] && ctrl[2] && ctrl[5:3] == 3'h7 && !kick_wr
		|=> !kick[0])
	else $error("software kick not cleared after move");

	a_kick_set: // [R11]
	assert property (kick_wr && wr_strb[0] && wr_data[1] |=> kick[1])
	else $error("software kick write lost");

	a_flag_clear: // [R20]
	assert property (sts_wr && wr_strb[1] && wr_data[13] && !g_ch[0].underrun
		|=> !flag[0])
	else $error("underrun flag one not cleared by write one");

	a_flag2_set: // [R21]
	assert property (g_ch[1].underrun |=> flag[1] ##1 (flag[1] || $past(sts_wr)))
	else $error("underrun flag two not set");

	a_irq_raise: // [R10]
	assert property (flag[1] && ctrl[29] && !sts_wr |=> underrun_irq[1])
	else $error("underrun interrupt not raised");

	a_byte_place: // [R25]
	assert property (do_write && widx == dac_pkg::IDX_H8R1 && wr_strb[0]
		|=> hold[0] == {$past(wr_data[7:0]), 4'h0})
	else $error("8-bit sample not placed in top bits");

	a_dual_load: // [R16]
	assert property (do_write && widx == dac_pkg::IDX_D12R && &wr_strb
		|=> hold[1] == $past(wr_data[27:16]) && hold[0] == $past(wr_data[11:0]))
	else $error("dual right word did not load both channels");

	a_out_ro: // [R19]
	assert property (do_write && widx == dac_pkg::IDX_OUT1 && !g_ch[0].move
		|=> code_one == $past(code_one))
	else $error("output code changed by a bus write");
endmodule : dac_ctrl

// ===== tb/dac_dma_model.sv
// Purpose: DMA controller stand-in that answers converter requests
// Assumes: requests are levels held until acknowledged
// Notes:   a long lag lets a second move arrive unanswered, provoking underrun
`timescale 1ns/1ps

module dac_dma_model (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// request handshake, index 0 is channel one
	input  wire logic [1:0] dma_req,
	input  wire logic [7:0] lag,
	output logic      [1:0] dma_ack
);
	logic [7:0] cnt [2];
	logic [1:0] done = 2'h0;

	initial dma_ack = 2'h0;

	// one acknowledge per request, lag plus one cycles after it rises
	always @(posedge aclk) begin
		for (int c = 0; c < 2; c++) begin
			dma_ack[c] <= 1'b0;
			if (!aresetn || !dma_req[c]) begin
				cnt[c] <= 8'h00;
				done[c] <= 1'b0;
			end else if (!done[c]) begin
				cnt[c] <= cnt[c] + 8'h01;
				if (cnt[c] >= lag) begin
					dma_ack[c] <= 1'b1;
					done[c] <= 1'b1;
				end
			end
		end
	end
endmodule : dac_dma_model

// ===== tb/dac_ctrl_tb.sv
// Purpose: self-checking bench of the dual converter control block
// Assumes: dac_dma_model answers DMA requests
// Notes:   bus answers are read just before the rising edge that takes them
`timescale 1ns/1ps

module dac_ctrl_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, d, q;
	logic [3:0]  wstrb = 4'hf, n;
	logic [1:0]  bresp, rresp, resp, dma_req, dma_ack, irq, on, boff;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [6:0]  ev = 7'h00;
	logic [7:0]  lag = 8'h02;
	logic [11:0] c1, c2, code_one, code_two, lfsr;
	int          errors = 0, total_checks = 0;

	always #4 aclk = ~aclk;

	dac_ctrl i_dac_ctrl (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .timer_six_trigger_out(ev[0]),
		.timer_eight_trigger_out(ev[1]), .timer_seven_trigger_out(ev[2]),
		.timer_five_trigger_out(ev[3]), .timer_two_trigger_out(ev[4]),
		.timer_four_trigger_out(ev[5]), .ext_line_nine(ev[6]), .dma_ack, .dma_req,
		.underrun_irq(irq), .chan_on(on), .chan_buffer_off(boff), .code_one, .code_two);

	dac_dma_model i_dac_dma_model (.aclk, .aresetn, .dma_req, .lag, .dma_ack);

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR %0t value %h expected %h", $time, s, e);
		end
	endtask : chk

	// each channel released at the edge that takes it
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		logic [2:0] p;
		logic [2:0] s;
		p = 3'h7;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (p != 3'h0) begin
			@(negedge aclk);
			s = {bvalid, wready, awready} & p;
			resp = bresp;
			@(posedge aclk);
			if (s[0]) awvalid <= 1'b0;
			if (s[1]) wvalid <= 1'b0;
			if (s[2]) bready <= 1'b0;
			p = p & ~s;
		end
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [31:0] v);
		logic [1:0] p;
		logic [1:0] s;
		p = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (p != 2'h0) begin
			@(negedge aclk);
			s = {rvalid, arready} & p;
			v = rdata;
			resp = rresp;
			@(posedge aclk);
			if (s[0]) arvalid <= 1'b0;
			if (s[1]) rready <= 1'b0;
			p = p & ~s;
		end
	endtask : rd

	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		rd(a, q);
		chk(q, e);
	endtask : rc

	// one-cycle event pulse; returns at the edge ending the pulse cycle
	task automatic kick(input logic [6:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= 7'h00;
	endtask : kick

	task automatic tend(input string n);
		$display("test %s done", n);
	endtask : tend

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// same half-word for both channels, channel on plus extra bits
	function automatic logic [31:0] cfg(input logic [2:0] s, input logic [15:0] x);
		logic [15:0] h;
		h = 16'h0001 | x | {10'h000, s, 3'h0};
		return {h, h};
	endfunction : cfg

	// codes after a write of d to holding register number f
	function automatic logic [23:0] fmt(input int f, input logic [31:0] d, input logic [23:0] o);
		logic [11:0] a;
		logic [11:0] b;
		a = (f % 3 == 0) ? d[11:0] : (f % 3 == 1) ? d[15:4] : {d[7:0], 4'h0};
		b = (f % 3 == 0) ? d[27:16] : (f % 3 == 1) ? d[31:20] : {d[15:8], 4'h0};
		return (f / 3 == 0) ? {o[23:12], a} : (f / 3 == 1) ? {a, o[11:0]} : {b, a};
	endfunction : fmt

	// readable bits of holding register number f, reserved bits read zero
	function automatic logic [31:0] hmask(input int f);
		logic [31:0] m;
		m = (f % 3 == 0) ? 32'h00000fff : (f % 3 == 1) ? 32'h0000fff0 : 32'h000000ff;
		return (f / 3 == 2) ? (m | (m << ((f % 3 == 2) ? 8 : 16))) : m;
	endfunction : hmask

	// noise mask or triangle peak for selector s, saturating at full scale
	function automatic logic [11:0] peak(input logic [3:0] s);
		return (s >= 4'hb) ? 12'hfff : 12'((13'h2 << s) - 13'h1);
	endfunction : peak

	// triangle value shown at move k for peak a: up to a, then down to zero
	function automatic logic [11:0] tri_at(input int k, input int a);
		int v;
		v = k % (2 * a);
		return 12'((v <= a) ? v : 2 * a - v);
	endfunction : tri_at

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		errors++;
		test_done();
	end

	initial begin
		void'($urandom(92460));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 56; a += 4) rc(a[5:0], 32'h0);
		tend("reset");
		repeat (4) begin
			d = $urandom;
			wr(dac_pkg::OFS_CTRL, d);
			rc(dac_pkg::OFS_CTRL, d & dac_pkg::CTRL_MASK);
			chk(on, {d[16], d[0]});
			chk(boff, {d[17], d[1]});
		end
		tend("control");
		wr(dac_pkg::OFS_CTRL, cfg(3'h0, 16'h0000));
		{c2, c1} = 24'h0;
		for (int f = 0; f < 9; f++) begin
			d = $urandom;
			wr(6'h08 + 6'(4 * f), d);
			{c2, c1} = fmt(f, d, {c2, c1});
			@(negedge aclk);
			chk(code_one, c1);
			chk(code_two, c2);
			rc(6'h08 + 6'(4 * f), d & hmask(f));
		end
		wr(dac_pkg::OFS_OUT1, ~d);
		chk(resp, dac_pkg::RESP_OKAY);
		rc(dac_pkg::OFS_OUT1, c1);
		rc(dac_pkg::OFS_OUT2, c2);
		rd(6'h38, q);
		chk(q, 32'h0);
		chk(resp, dac_pkg::RESP_SLVERR);
		wr(6'h38, d);
		chk(resp, dac_pkg::RESP_SLVERR);
		tend("formats");
		for (int s = 0; s < 8; s++) begin
			wr(dac_pkg::OFS_CTRL, cfg(s[2:0], 16'h0004));
			d = $urandom & 32'h0fff0fff;
			wr(dac_pkg::OFS_D12R, d);
			kick(7'h7f & ~(7'h01 << s));
			repeat (3) @(negedge aclk);
			chk(code_one, c1);
			chk(code_two, c2);
			if (s == 7) begin
				wr(dac_pkg::OFS_SWT, 32'h3);
			end else begin
				kick(7'h01 << s);
				repeat (2) @(negedge aclk);
				chk(code_one, c1);
			end
			@(negedge aclk);
			{c2, c1} = {d[27:16], d[11:0]};
			chk(code_one, c1);
			chk(code_two, c2);
		end
		tend("triggers");
		lag <= 8'd200;
		wr(dac_pkg::OFS_CTRL, cfg(3'h7, 16'h3004));
		repeat (2) wr(dac_pkg::OFS_SWT, 32'h3);
		@(negedge aclk);
		chk(dma_req, 2'h3);
		rc(dac_pkg::OFS_STS, 32'h20002000);
		chk(irq, 2'h3);
		wr(dac_pkg::OFS_STS, 32'h0);
		rc(dac_pkg::OFS_STS, 32'h20002000);
		wr(dac_pkg::OFS_STS, 32'h20002000);
		rc(dac_pkg::OFS_STS, 32'h0);
		chk(irq, 2'h0);
		lag <= 8'd2;
		repeat (6) @(negedge aclk);
		chk(dma_req, 2'h0);
		tend("dma");
		// channel one noise with a random mask, channel two triangle of peak 3
		n = 4'($urandom);
		wr(dac_pkg::OFS_CTRL, {16'h01bd, 4'h0, n, 8'h7d});
		d = $urandom & 32'h0fff0fff;
		wr(dac_pkg::OFS_D12R, d);
		lfsr = dac_pkg::LFSR_SEED;
		for (int k = 0; k < 8; k++) begin
			wr(dac_pkg::OFS_SWT, 32'h3);
			@(negedge aclk);
			chk(code_one, 12'(d[11:0] + (lfsr & peak(n))));
			chk(code_two, 12'(d[27:16] + tri_at(k, peak(4'h1))));
			lfsr = {lfsr[10:0], ^(lfsr & dac_pkg::LFSR_TAPS)};
		end
		tend("waves");
		test_done();
	end
endmodule : dac_ctrl_tb
